// File: mtpt_pkg.sv
// constants shared by the transmit pause timer block
// assumes a 32-bit register port with byte addresses and a 20 MHz clock

package mtpt_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int COUNT_W = 16;
   localparam int PRIO_N = 8;
   localparam int TIMER_N = 9;
   localparam int INDEX_W = 4;

   // ----------------------------------------
   // register offsets, byte addresses
   // ----------------------------------------
   localparam logic [7:0] REG_STD_OFS = 8'h00;
   localparam logic [7:0] REG_PRIO_BASE = 8'h04;
   localparam logic [7:0] REG_STRIDE = 8'h04;
   localparam logic [7:0] REG_LAST_TIMER = 8'h20;
   localparam logic [7:0] REG_EMU_OFS = 8'h24;
   localparam logic [7:0] REG_CTRL_OFS = 8'h28;
   localparam logic [7:0] REG_STAT_OFS = 8'h2c;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int EMU_SOFT_BIT = 1;
   localparam int EMU_FREE_BIT = 0;
   localparam int CTRL_TEST_BIT = 0;
   localparam int STAT_STD_BIT = 0;
   localparam int STAT_PRIO_LSB = 1;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [1:0] EMU_RESET = 2'h0;
   localparam logic CTRL_TEST_RESET = 1'b0;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SLOT_TIME_NS = 512;
   localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLOT_W = 4;

endpackage

// File: mtpt_slot_tick.sv
// slot time pulse generator for the pause timers
// assumes one free running clock and a synchronous reset
`timescale 1ns/100ps

module mtpt_slot_tick
   import mtpt_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // one-cycle pulse per slot time
   output logic tick_o
);
   import mtpt_pkg::*;

   localparam logic [SLOT_W-1:0] LAST = SLOT_W'(SLOT_CYCLES - 1);

   logic [SLOT_W-1:0] phase;
   wire at_last = (phase == LAST);
   wire [SLOT_W-1:0] next_phase = at_last ? '0 : phase + SLOT_W'(1);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         phase <= '0;
         tick_o <= 1'b0;
      end else begin
         phase <= next_phase;
         tick_o <= at_last;
      end
   end

endmodule

// File: mtpt_pause_timer.sv
// one 16-bit transmit pause down counter
// assumes load and write requests come from logic on the same clock
`timescale 1ns/100ps

module mtpt_pause_timer
   import mtpt_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // pause frame load
   input wire logic load_i,
   input wire logic [COUNT_W-1:0] load_value_i,
   // software write, already qualified by test mode
   input wire logic write_i,
   input wire logic [COUNT_W-1:0] write_value_i,
   // slot time pulse
   input wire logic tick_i,
   // current count
   output logic [COUNT_W-1:0] count_o
);
   import mtpt_pkg::*;

   wire nonzero = (count_o != COUNT_RESET);
   wire [COUNT_W-1:0] decremented = count_o - COUNT_W'(1);
   // a frame load wins over a software write, then the slot decrement
   wire [COUNT_W-1:0] next_count = load_i ? load_value_i :
                                   write_i ? write_value_i :
                                   (tick_i && nonzero) ? decremented : count_o;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         count_o <= COUNT_RESET;
      end else begin
         count_o <= next_count;
      end
   end

endmodule

// File: mtpt_top.sv
// transmit pause timers of one mac port: one whole-link timer, eight priority timers
// assumes pause frame decode upstream on mclk_i, and a single-cycle strobe register port
`timescale 1ns/100ps

module mtpt_top
   import mtpt_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // register port
   input wire logic [mtpt_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [mtpt_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [mtpt_pkg::DATA_W-1:0] reg_rdata_o,
   // decoded pause frames from the receive side
   input wire logic pause_valid_i,
   input wire logic pause_is_prio_i,
   input wire logic [mtpt_pkg::COUNT_W-1:0] pause_time_i,
   input wire logic [mtpt_pkg::PRIO_N-1:0] pause_prio_enable_i,
   input wire logic [mtpt_pkg::PRIO_N*mtpt_pkg::COUNT_W-1:0] pause_prio_time_i,
   // transmit gating
   output logic tx_pause_hold_o,
   output logic [mtpt_pkg::PRIO_N-1:0] tx_prio_hold_o,
   // debug suspend control
   output logic emu_soft_o,
   output logic emu_free_o
);
   import mtpt_pkg::*;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic test_mode;
   logic [1:0] debug_suspend_control;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire addr_aligned = (reg_addr_i[1:0] == 2'h0);
   wire timer_hit = addr_aligned && (reg_addr_i <= REG_LAST_TIMER);
   wire [INDEX_W-1:0] timer_index = reg_addr_i[INDEX_W+1:2];
   wire emu_hit = (reg_addr_i == REG_EMU_OFS);
   wire ctrl_hit = (reg_addr_i == REG_CTRL_OFS);
   wire stat_hit = (reg_addr_i == REG_STAT_OFS);
   wire emu_wr = reg_wr_i && emu_hit;
   wire ctrl_wr = reg_wr_i && ctrl_hit;

   // ----------------------------------------
   // pause frame steering
   // ----------------------------------------
   wire std_frame = pause_valid_i && !pause_is_prio_i;
   wire prio_frame = pause_valid_i && pause_is_prio_i;

   // ----------------------------------------
   // slot time
   // ----------------------------------------
   logic slot_tick;

   mtpt_slot_tick u_slot_tick (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .tick_o(slot_tick)
   );

   // ----------------------------------------
   // timers: index 0 whole-link, 1 to 8 priorities 0 to 7
   // ----------------------------------------
   logic [COUNT_W-1:0] count [TIMER_N];
   logic [TIMER_N-1:0] timer_load;
   logic [TIMER_N-1:0] timer_write;
   logic [COUNT_W-1:0] timer_value [TIMER_N];
   logic [TIMER_N-1:0] timer_busy;

   assign timer_load[0] = std_frame;
   assign timer_value[0] = pause_time_i;

   genvar gi;
   generate
      for (gi = 0; gi < PRIO_N; gi = gi + 1) begin : g_prio_load
         assign timer_load[gi+1] = prio_frame && pause_prio_enable_i[gi];
         assign timer_value[gi+1] = pause_prio_time_i[gi*COUNT_W +: COUNT_W];
      end
      for (gi = 0; gi < TIMER_N; gi = gi + 1) begin : g_timer
         assign timer_write[gi] = reg_wr_i && test_mode && timer_hit && (timer_index == INDEX_W'(gi));
         assign timer_busy[gi] = (count[gi] != COUNT_RESET);
         mtpt_pause_timer u_timer (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .load_i(timer_load[gi]),
            .load_value_i(timer_value[gi]),
            .write_i(timer_write[gi]),
            .write_value_i(reg_wdata_i[COUNT_W-1:0]),
            .tick_i(slot_tick),
            .count_o(count[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // read selection
   // ----------------------------------------
   wire [DATA_W-1:0] timer_word = {16'h0000, count[timer_index]};
   wire [DATA_W-1:0] emu_word = {30'h00000000, debug_suspend_control};
   wire [DATA_W-1:0] ctrl_word = {31'h00000000, test_mode};
   wire [DATA_W-1:0] stat_word = {23'h000000, timer_busy[TIMER_N-1:1], timer_busy[0]};
   wire [DATA_W-1:0] read_word = timer_hit ? timer_word :
                                 emu_hit ? emu_word :
                                 ctrl_hit ? ctrl_word :
                                 stat_hit ? stat_word : 32'h00000000;
   wire [DATA_W-1:0] next_rdata = reg_rd_i ? read_word : 32'h00000000;

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         test_mode <= CTRL_TEST_RESET;
         debug_suspend_control <= EMU_RESET;
      end else begin
         if (ctrl_wr) begin
            test_mode <= reg_wdata_i[CTRL_TEST_BIT];
         end
         if (emu_wr) begin
            debug_suspend_control <= reg_wdata_i[EMU_SOFT_BIT:EMU_FREE_BIT];
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 32'h00000000;
         tx_pause_hold_o <= 1'b0;
         tx_prio_hold_o <= 8'h00;
         emu_soft_o <= 1'b0;
         emu_free_o <= 1'b0;
      end else begin
         reg_rdata_o <= next_rdata;
         tx_pause_hold_o <= timer_busy[0];
         tx_prio_hold_o <= timer_busy[TIMER_N-1:1];
         emu_soft_o <= debug_suspend_control[EMU_SOFT_BIT];
         emu_free_o <= debug_suspend_control[EMU_FREE_BIT];
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_std_frame;
      std_frame;
   endsequence

   sequence s_std_loaded;
      count[0] == $past(pause_time_i);
   endsequence

   sequence s_quiet_std;
      !std_frame && !timer_write[0];
   endsequence

   AST_STD_LOAD: assert property (s_std_frame |=> s_std_loaded)
      else $error("standard timer not loaded by pause frame");

   AST_STD_DECREMENT: assert property (
      (slot_tick && timer_busy[0]) ##0 s_quiet_std |=> count[0] == $past(count[0]) - 16'h0001)
      else $error("standard timer did not step down on slot tick");

   AST_STD_ZERO_HOLDS: assert property (
      !timer_busy[0] ##0 s_quiet_std |=> !timer_busy[0])
      else $error("standard timer left zero without a load");

   AST_STD_IDLE_BETWEEN_TICKS: assert property (
      !slot_tick ##0 s_quiet_std |=> $stable(count[0]))
      else $error("standard timer moved between slot ticks");

   AST_HOLD_FOLLOWS_COUNT: assert property (
      timer_busy[0] |=> tx_pause_hold_o)
      else $error("transmit not held while standard timer nonzero");

   AST_RELEASE_AT_ZERO: assert property (
      !timer_busy[0] |=> !tx_pause_hold_o)
      else $error("transmit still held with standard timer at zero");

   AST_LOAD_THEN_HOLD: assert property (
      std_frame && (pause_time_i != COUNT_RESET) |=> ##1 tx_pause_hold_o)
      else $error("nonzero pause frame did not hold transmit");

   AST_TEST_WRITE: assert property (
      reg_wr_i && test_mode && (reg_addr_i == REG_STD_OFS) && !std_frame
      |=> count[0] == $past(reg_wdata_i[COUNT_W-1:0]))
      else $error("test mode write did not set the standard timer");

   AST_NO_WRITE_OUTSIDE_TEST: assert property (
      reg_wr_i && !test_mode && (reg_addr_i == REG_STD_OFS) && !std_frame && !slot_tick
      |=> $stable(count[0]))
      else $error("write changed the standard timer outside test mode");

   AST_READ_COUNT: assert property (
      reg_rd_i && (reg_addr_i == REG_STD_OFS) |=> reg_rdata_o == {16'h0000, $past(count[0])})
      else $error("read of standard timer returned wrong value");

   AST_READ_ONE_CYCLE: assert property (
      !reg_rd_i |=> reg_rdata_o == 32'h00000000)
      else $error("read data present without a read strobe");

   AST_PRIO_FRAME_SPARES_STD: assert property (
      prio_frame && !slot_tick && !timer_write[0] |=> $stable(count[0]))
      else $error("priority frame disturbed the standard timer");

   AST_STD_FRAME_SPARES_PRIO: assert property (
      std_frame && !slot_tick && !reg_wr_i |=> $stable(count[1]) && $stable(count[8]))
      else $error("standard frame disturbed a priority timer");

   AST_PRIO0_LOAD: assert property (
      prio_frame && pause_prio_enable_i[0] |=> count[1] == $past(pause_prio_time_i[15:0]))
      else $error("priority 0 timer not loaded from its time field");

   AST_PRIO7_DISABLED: assert property (
      prio_frame && !pause_prio_enable_i[7] && !slot_tick && !reg_wr_i |=> $stable(count[8]))
      else $error("disabled priority 7 timer was loaded");

   AST_PRIO_HOLD_OWN: assert property (
      timer_busy[4] && !timer_busy[5] |=> tx_prio_hold_o[3] && !tx_prio_hold_o[4])
      else $error("priority hold not tied to its own timer");

   AST_EMU_LAYOUT: assert property (
      emu_wr |=> ##1 (emu_soft_o == $past(reg_wdata_i[1], 2)) && (emu_free_o == $past(reg_wdata_i[0], 2)))
      else $error("debug suspend bits not stored at their positions");

   AST_EMU_RESERVED: assert property (
      reg_rd_i && emu_hit |=> reg_rdata_o[31:2] == 30'h00000000)
      else $error("reserved debug suspend bits read nonzero");

   // ----------------------------------------
   // reset, slot tick, priority timers and register port
   // ----------------------------------------
   sequence s_quiet_prio;
      !prio_frame && !reg_wr_i;
   endsequence

   AST_RESET_COUNTS: assert property (@(posedge mclk_i) disable iff (1'b0)
      reset_i |=> (count[0] == COUNT_RESET) && (count[8] == COUNT_RESET) && (test_mode == CTRL_TEST_RESET))
      else $error("timer counts not cleared by reset");

   AST_RESET_EMU: assert property (@(posedge mclk_i) disable iff (1'b0)
      reset_i |=> (debug_suspend_control == EMU_RESET) && !emu_soft_o && !emu_free_o)
      else $error("debug suspend bits not cleared by reset");

   AST_RESET_HOLDS: assert property (@(posedge mclk_i) disable iff (1'b0)
      reset_i |=> !tx_pause_hold_o && (tx_prio_hold_o == 8'h00) && (reg_rdata_o == 32'h00000000))
      else $error("holds or read data not cleared by reset");

   AST_TICK_ONE_CYCLE: assert property (
      slot_tick |=> !slot_tick)
      else $error("slot tick longer than one cycle");

   AST_TICK_PERIOD: assert property (
      slot_tick |-> ##SLOT_CYCLES slot_tick)
      else $error("slot tick spacing differs from the slot time");

   AST_PRIO_DECREMENT: assert property (
      (slot_tick && (count[1] != COUNT_RESET)) ##0 s_quiet_prio |=> count[1] == $past(count[1]) - 16'h0001)
      else $error("priority 0 timer did not step down on slot tick");

   AST_PRIO_ZERO_HOLDS: assert property (
      (count[1] == COUNT_RESET) ##0 s_quiet_prio |=> count[1] == COUNT_RESET)
      else $error("priority 0 timer left zero without a load");

   AST_PRIO_IDLE_BETWEEN_TICKS: assert property (
      !slot_tick ##0 s_quiet_prio |=> $stable(count[8]))
      else $error("priority 7 timer moved between slot ticks");

   AST_PRIO7_LOAD: assert property (
      prio_frame && pause_prio_enable_i[7] |=> count[8] == $past(pause_prio_time_i[7*COUNT_W +: COUNT_W]))
      else $error("priority 7 timer not loaded from its time field");

   AST_PRIO_INDEPENDENT: assert property (
      prio_frame && !pause_prio_enable_i[1] && !slot_tick && !reg_wr_i |=> $stable(count[2]))
      else $error("disabled priority 1 timer was loaded");

   AST_PRIO_HOLD_MATCHES: assert property (
      1'b1 |=> (tx_prio_hold_o[0] == ($past(count[1]) != COUNT_RESET))
         && (tx_prio_hold_o[7] == ($past(count[8]) != COUNT_RESET)))
      else $error("priority hold does not follow its timer");

   AST_PRIO_TEST_WRITE: assert property (
      reg_wr_i && test_mode && (reg_addr_i == REG_PRIO_BASE + 8'h03 * REG_STRIDE) && !prio_frame
      |=> count[4] == $past(reg_wdata_i[COUNT_W-1:0]))
      else $error("test mode write did not set the priority 3 timer");

   AST_WRITE_OUTSIDE_TEST_ANY: assert property (
      reg_wr_i && !test_mode && !pause_valid_i && !slot_tick
      |=> $stable(count[0]) && $stable(count[4]) && $stable(count[8]))
      else $error("write changed a timer outside test mode");

   AST_READ_PRIO: assert property (
      reg_rd_i && (reg_addr_i == REG_PRIO_BASE) |=> reg_rdata_o == {16'h0000, $past(count[1])})
      else $error("read of priority 0 timer returned wrong value");

   AST_READ_CTRL: assert property (
      reg_rd_i && (reg_addr_i == REG_CTRL_OFS) |=> reg_rdata_o == {31'h00000000, $past(test_mode)})
      else $error("read of control register returned wrong value");

   AST_READ_STATUS: assert property (
      reg_rd_i && (reg_addr_i == REG_STAT_OFS)
      |=> (reg_rdata_o[STAT_STD_BIT] == ($past(count[0]) != COUNT_RESET))
         && (reg_rdata_o[STAT_PRIO_LSB] == ($past(count[1]) != COUNT_RESET)))
      else $error("status bits do not follow their timers");

   AST_TIMER_UPPER_ZERO: assert property (
      reg_rd_i && (reg_addr_i <= REG_LAST_TIMER) |=> reg_rdata_o[31:16] == 16'h0000)
      else $error("reserved timer bits read nonzero");

   AST_UNMAPPED_READ_ZERO: assert property (
      reg_rd_i && (reg_addr_i > REG_STAT_OFS) |=> reg_rdata_o == 32'h00000000)
      else $error("unmapped read returned nonzero data");

   AST_EMU_WRITE_DECODE: assert property (
      reg_wr_i && (reg_addr_i != REG_EMU_OFS) |=> $stable(debug_suspend_control))
      else $error("debug suspend bits changed by a write elsewhere");

endmodule

// File: mtpt_link_peer.sv
// link partner model: hands decoded pause frames to the timer block
// assumes the bench calls send from the mclk_i domain
`timescale 1ns/100ps

module mtpt_link_peer
   import mtpt_pkg::*;
(
   // clock
   input wire logic mclk_i,
   // decoded pause frame
   output logic pause_valid_o,
   output logic pause_is_prio_o,
   output logic [mtpt_pkg::COUNT_W-1:0] pause_time_o,
   output logic [mtpt_pkg::PRIO_N-1:0] pause_prio_enable_o,
   output logic [mtpt_pkg::PRIO_N*mtpt_pkg::COUNT_W-1:0] pause_prio_time_o
);
   initial begin
      pause_valid_o = 1'b0;
      pause_is_prio_o = 1'b0;
      pause_time_o = '0;
      pause_prio_enable_o = '0;
      pause_prio_time_o = '0;
   end

   // one frame per call; fields are scrambled once the frame is over
   task automatic send(input logic prio, input logic [COUNT_W-1:0] t, input logic [PRIO_N-1:0] en,
      input logic [PRIO_N*COUNT_W-1:0] pt);
      @(posedge mclk_i);
      pause_valid_o <= 1'b1;
      pause_is_prio_o <= prio;
      pause_time_o <= t;
      pause_prio_enable_o <= en;
      pause_prio_time_o <= pt;
      @(posedge mclk_i);
      pause_valid_o <= 1'b0;
      pause_is_prio_o <= ~prio;
      pause_time_o <= ~t;
      pause_prio_enable_o <= ~en;
      pause_prio_time_o <= ~pt;
   endtask
endmodule

// File: mac_tx_pause_timers_tb.sv
// self-checking bench for the transmit pause timers
// assumes the link peer model drives the pause frame inputs
`timescale 1ns/100ps

module mac_tx_pause_timers_tb;
   import mtpt_pkg::*;
   logic mclk_i, reset_i, reg_wr_i, reg_rd_i, pause_valid_i, pause_is_prio_i;
   logic tx_pause_hold_o, emu_soft_o, emu_free_o;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, d;
   logic [COUNT_W-1:0] pause_time_i;
   logic [PRIO_N-1:0] pause_prio_enable_i, tx_prio_hold_o;
   logic [PRIO_N*COUNT_W-1:0] pause_prio_time_i;
   int failures = 0;
   int samples_checked = 0;

   mtpt_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pause_valid_i(pause_valid_i),
      .pause_is_prio_i(pause_is_prio_i), .pause_time_i(pause_time_i), .pause_prio_enable_i(pause_prio_enable_i),
      .pause_prio_time_i(pause_prio_time_i), .tx_pause_hold_o(tx_pause_hold_o), .tx_prio_hold_o(tx_prio_hold_o),
      .emu_soft_o(emu_soft_o), .emu_free_o(emu_free_o));
   mtpt_link_peer i_peer (.mclk_i(mclk_i), .pause_valid_o(pause_valid_i), .pause_is_prio_o(pause_is_prio_i),
      .pause_time_o(pause_time_i), .pause_prio_enable_o(pause_prio_enable_i),
      .pause_prio_time_o(pause_prio_time_i));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      reg_wdata_i <= ~v;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values;
      for (int i = 0; i <= 12; i++) begin
         rd(8'(i * 4));
         check("reset value", d, 32'h0);
      end
   endtask

   task automatic t_debug_suspend;
      wr(REG_EMU_OFS, 32'hffffffff);
      rd(REG_EMU_OFS);
      check("suspend read", d, 32'h3);
      check("suspend pins", {emu_soft_o, emu_free_o}, 32'h3);
      wr(REG_EMU_OFS, 32'h2);
      rd(REG_EMU_OFS);
      check("soft only", {emu_soft_o, emu_free_o, d[1:0]}, 32'ha);
   endtask

   task automatic t_test_write;
      wr(8'h10, 32'habcd1234);
      wr(REG_STD_OFS, 32'h00000005);
      rd(8'h10);
      check("write outside test", d, 32'h0);
      rd(REG_STD_OFS);
      check("std write outside test", d, 32'h0);
      wr(REG_CTRL_OFS, 32'h1);
      wr(8'h10, 32'habcd1234);
      rd(8'h10);
      check("write in test", d == 32'h1234 || d == 32'h1233, 32'h1);
      check("prio3 hold", {tx_pause_hold_o, tx_prio_hold_o}, 32'h08);
      wr(REG_STD_OFS, 32'h00010007);
      rd(REG_STD_OFS);
      check("std write in test", d == 32'h7 || d == 32'h6, 32'h1);
      check("std and prio3 hold", {tx_pause_hold_o, tx_prio_hold_o}, 32'h108);
      wr(8'h10, 32'h0);
      wr(REG_STD_OFS, 32'h0);
      wr(REG_CTRL_OFS, 32'h0);
      rd(8'h10);
      check("hold cleared", {tx_pause_hold_o, tx_prio_hold_o}, 32'h0);
      check("count cleared", d, 32'h0);
   endtask

   task automatic t_std_pause;
      int c;
      i_peer.send(1'b0, 16'h0003, 8'hff, {PRIO_N{16'h0005}});
      rd(REG_STD_OFS);
      check("loaded count", d == 32'h3 || d == 32'h2, 32'h1);
      check("std hold", {tx_pause_hold_o, tx_prio_hold_o}, 32'h100);
      c = 2;
      while (tx_pause_hold_o === 1'b1 && c < 60) begin
         @(posedge mclk_i);
         #1 c++;
      end
      check("slot countdown", c >= 24 && c <= 34, 32'h1);
      rd(REG_STD_OFS);
      check("std at zero", d, 32'h0);
      rd(REG_PRIO_BASE);
      check("prio untouched", d, 32'h0);
   endtask

   task automatic t_prio_pause;
      logic [PRIO_N*COUNT_W-1:0] pt;
      logic [PRIO_N-1:0] en;
      int c;
      en = 8'ha5;
      for (int n = 0; n < PRIO_N; n++) begin
         pt[16*n +: 16] = 16'(n + 2);
      end
      i_peer.send(1'b1, 16'hffff, en, pt);
      @(posedge mclk_i);
      #1 check("prio holds", {tx_pause_hold_o, tx_prio_hold_o}, 32'ha5);
      rd(REG_STAT_OFS);
      check("status", d, 32'h14a);
      for (int n = 0; n < PRIO_N; n++) begin
         rd(8'(4 + 4 * n));
         check("prio count", (d[15:0] <= pt[16*n +: 16]) && ((d != 32'h0) == en[n]), 32'h1);
      end
      c = 0;
      while (tx_prio_hold_o[2] !== 1'b0 && c < 60) begin
         @(posedge mclk_i);
         #1 c++;
      end
      check("independent release", tx_prio_hold_o, 32'ha0);
      c = 0;
      while (tx_prio_hold_o !== 8'h0 && c < 60) begin
         @(posedge mclk_i);
         #1 c++;
      end
      check("all released", {tx_pause_hold_o, tx_prio_hold_o}, 32'h0);
   endtask

   // ----------------------------------------
   // clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   initial begin
      reset_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_reset_values();
      t_debug_suspend();
      t_test_write();
      t_std_pause();
      t_prio_pause();
      complete_run();
   end

   initial begin
      #(CLK_PERIOD_NS * 5000);
      failures++;
      complete_run();
   end
endmodule
